// ---- core/sma_mem_access.sv ----
// Memory access command interpreter with AXI4-Lite register slave
// Notes on behaviour
// - Command 08 writes full idle byte
// - Commands 18/10 write high/low nibble
// - Commands 38/30/28/20 write bit pairs
// - Command 88 returns data memory byte
// - Command 60 writes one tristate field
// - Command 68 writes all tristate fields
// - Command E0 reads one tristate field
// - Command 48 writes data, keeps code
// - Command C8 reads connection data field
// - Command F0 reads connection code field
// - 70 unassigns, 71 sets 8-bit switch
// - 73/72 select 4-bit switched halves
// - 77..74 select 2-bit switched pairs
// - 79 declares microprocessor channel, stores idle
// - 7X writes code and data together
`timescale 1ns/1ps
module sma_mem_access
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address channel
    input wire logic [sma_pkg::SMA_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // Write data channel
    input wire logic [sma_pkg::SMA_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // Write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read address channel
    input wire logic [sma_pkg::SMA_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // Read data channel
    output logic [sma_pkg::SMA_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Status
    output logic mem_access_busy
);
    import sma_pkg::*;

    logic [7:0] mem_access_data_reg;
    logic [7:0] mem_access_address_reg;
    logic [7:0] mem_access_command_reg;
    logic [7:0] switch_data_memory [SMA_DM_DEPTH];
    logic [3:0] tristate_field [SMA_TS_DEPTH];
    logic [7:0] cm_data_field [SMA_CM_DEPTH];
    logic [3:0] connection_code_bits [SMA_CM_DEPTH];
    sma_state_t state;
    sma_op_t op;
    logic [7:0] dm_mask;
    logic [SMA_ADDR_W-1:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane0;
    logic wr_go;
    logic [2:0] wr_sel;
    logic wr_refused;
    logic sw_wr_data;
    logic sw_wr_addr;
    logic cmd_fire;
    logic [2:0] rd_sel;
    logic [SMA_DATA_W-1:0] rd_word;
    logic exec;
    logic [6:0] ts_idx;
    logic [3:0] data_lo;
    logic [3:0] cmd_lo;
    logic [7:0] dm_cur;
    logic [3:0] ts_cur;
    logic [7:0] cm_cur;
    logic [3:0] code_cur;

    // Register select from a byte address
    function automatic logic [2:0] reg_sel(input logic [SMA_ADDR_W-1:0] addr);
        case (addr)
            SMA_OFF_DATA: reg_sel = SMA_SEL_DATA;
            SMA_OFF_ADDR: reg_sel = SMA_SEL_ADDR;
            SMA_OFF_CMD: reg_sel = SMA_SEL_CMD;
            SMA_OFF_STAT: reg_sel = SMA_SEL_STAT;
            default: reg_sel = SMA_SEL_NONE;
        endcase
    endfunction

    sma_cmd_decode u_decode
    (
        .mem_access_command_reg(mem_access_command_reg),
        .op(op),
        .dm_mask(dm_mask)
    );

    assign exec = (state == SMA_ST_EXEC);
    assign ts_idx = mem_access_address_reg[6:0];
    assign data_lo = mem_access_data_reg[3:0];
    assign cmd_lo = mem_access_command_reg[3:0];
    assign dm_cur = switch_data_memory[mem_access_address_reg];
    assign ts_cur = tristate_field[ts_idx];
    assign cm_cur = cm_data_field[mem_access_address_reg];
    assign code_cur = connection_code_bits[mem_access_address_reg];

    // Write decode; registers are locked while an operation runs
    assign wr_go = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    assign wr_sel = reg_sel(aw_addr);
    assign wr_refused = (wr_sel == SMA_SEL_NONE) ||
                        (mem_access_busy && wr_sel != SMA_SEL_STAT);
    assign sw_wr_data = wr_go && !wr_refused && w_lane0 && wr_sel == SMA_SEL_DATA;
    assign sw_wr_addr = wr_go && !wr_refused && w_lane0 && wr_sel == SMA_SEL_ADDR;
    assign cmd_fire = wr_go && !wr_refused && w_lane0 && wr_sel == SMA_SEL_CMD;

    // Write address and data capture, taken in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_addr <= '0;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                s_axi_awready <= 1'b0;
                aw_addr <= s_axi_awaddr;
            end
            else if (wr_go)
            begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                s_axi_wready <= 1'b0;
                w_byte <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
            else if (wr_go)
            begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Write response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= SMA_RESP_OKAY;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_refused ? SMA_RESP_SLVERR : SMA_RESP_OKAY;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read word assembly
    assign rd_sel = reg_sel(s_axi_araddr);
    always_comb
    begin
        rd_word = '0;
        case (rd_sel)
            SMA_SEL_DATA: rd_word[7:0] = mem_access_data_reg;
            SMA_SEL_ADDR: rd_word[7:0] = mem_access_address_reg;
            SMA_SEL_CMD: rd_word[7:0] = mem_access_command_reg;
            SMA_SEL_STAT: rd_word[SMA_STAT_BUSY_BIT] = mem_access_busy;
            default: rd_word = '0;
        endcase
    end

    // Read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= SMA_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= (rd_sel == SMA_SEL_NONE) ? SMA_RESP_SLVERR : SMA_RESP_OKAY;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Address and command registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mem_access_address_reg <= SMA_RST_REG;
            mem_access_command_reg <= SMA_RST_REG;
        end
        else
        begin
            if (sw_wr_addr)
            begin
                mem_access_address_reg <= w_byte;
            end
            if (cmd_fire)
            begin
                mem_access_command_reg <= w_byte;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= SMA_ST_IDLE;
            mem_access_busy <= 1'b0;
        end
        else
        begin
            case (state)
                SMA_ST_IDLE:
                begin
                    if (cmd_fire)
                    begin
                        state <= SMA_ST_EXEC;
                        mem_access_busy <= 1'b1;
                    end
                end
                SMA_ST_EXEC:
                begin
                    state <= SMA_ST_IDLE;
                    mem_access_busy <= 1'b0;
                end
                default:
                begin
                    state <= SMA_ST_IDLE;
                    mem_access_busy <= 1'b0;
                end
            endcase
        end
    end

    // Data register: software load or read-back result
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mem_access_data_reg <= SMA_RST_REG;
        end
        else if (sw_wr_data)
        begin
            mem_access_data_reg <= w_byte;
        end
        else if (exec)
        begin
            case (op)
                SMA_OP_DM_RD: mem_access_data_reg <= dm_cur;
                SMA_OP_TS_RD: mem_access_data_reg <= {4'h0, ts_cur};
                SMA_OP_CM_DRD: mem_access_data_reg <= cm_cur;
                SMA_OP_CM_CRD: mem_access_data_reg <= {4'h0, code_cur};
                default: mem_access_data_reg <= mem_access_data_reg;
            endcase
        end
    end

    // Data memory idle writes
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < SMA_DM_DEPTH; i++)
            begin
                switch_data_memory[i] <= SMA_RST_DM;
            end
        end
        else if (exec && op == SMA_OP_DM_WR)
        begin
            switch_data_memory[mem_access_address_reg] <=
                (dm_cur & ~dm_mask) | (mem_access_data_reg & dm_mask);
        end
    end

    // Tristate field writes
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < SMA_TS_DEPTH; i++)
            begin
                tristate_field[i] <= SMA_RST_TS;
            end
        end
        else if (exec && op == SMA_OP_TS_WR)
        begin
            tristate_field[ts_idx] <= data_lo;
        end
        else if (exec && op == SMA_OP_TS_ALL)
        begin
            for (int i = 0; i < SMA_TS_DEPTH; i++)
            begin
                tristate_field[i] <= data_lo;
            end
        end
    end

    // Connection memory writes
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < SMA_CM_DEPTH; i++)
            begin
                cm_data_field[i] <= SMA_RST_REG;
                connection_code_bits[i] <= SMA_RST_CODE;
            end
        end
        else if (exec && op == SMA_OP_CM_DWR)
        begin
            cm_data_field[mem_access_address_reg] <= mem_access_data_reg;
        end
        else if (exec && op == SMA_OP_CM_CWR)
        begin
            cm_data_field[mem_access_address_reg] <= mem_access_data_reg;
            connection_code_bits[mem_access_address_reg] <= cmd_lo;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_cmd_sets_busy: assert property (cmd_fire |=> mem_access_busy ##1 !mem_access_busy)
        else $error("busy not one cycle after command");
    a_dm_full_write: assert property (exec && mem_access_command_reg == 8'h08 |=>
        switch_data_memory[$past(mem_access_address_reg)] == $past(mem_access_data_reg))
        else $error("full idle write wrong");
    a_dm_nibble_write: assert property (exec && mem_access_command_reg == 8'h18 |=>
        switch_data_memory[$past(mem_access_address_reg)] ==
        (($past(mem_access_data_reg) & 8'hf0) | ($past(dm_cur) & 8'h0f)))
        else $error("high nibble idle write wrong");
    a_dm_pair_write: assert property (exec && mem_access_command_reg == 8'h30 |=>
        switch_data_memory[$past(mem_access_address_reg)] ==
        (($past(mem_access_data_reg) & 8'h30) | ($past(dm_cur) & 8'hcf)))
        else $error("bit pair idle write wrong");
    a_dm_read_back: assert property (exec && mem_access_command_reg == 8'h88 |=>
        mem_access_data_reg == $past(dm_cur))
        else $error("data memory read wrong");
    a_ts_single: assert property (exec && mem_access_command_reg == 8'h60 |=>
        tristate_field[$past(ts_idx)] == $past(data_lo))
        else $error("tristate write wrong");
    a_ts_broadcast: assert property (exec && mem_access_command_reg == 8'h68 |=>
        tristate_field[0] == $past(data_lo) &&
        tristate_field[SMA_TS_DEPTH-1] == $past(data_lo))
        else $error("tristate broadcast wrong");
    a_ts_read_back: assert property (exec && mem_access_command_reg == 8'he0 |=>
        mem_access_data_reg == {4'h0, $past(ts_cur)})
        else $error("tristate read wrong");
    a_cm_data_only: assert property (exec && mem_access_command_reg == 8'h48 |=>
        cm_data_field[$past(mem_access_address_reg)] == $past(mem_access_data_reg) &&
        connection_code_bits[$past(mem_access_address_reg)] == $past(code_cur))
        else $error("data field write wrong");
    a_cm_read_back: assert property (exec && mem_access_command_reg == 8'hc8 |=>
        mem_access_data_reg == $past(cm_cur))
        else $error("data field read wrong");
    a_code_read_back: assert property (exec && mem_access_command_reg[7:4] == 4'hf |=>
        mem_access_data_reg == {4'h0, $past(code_cur)})
        else $error("code field read wrong");
    a_code_write: assert property (exec && mem_access_command_reg[7:4] == 4'h7 |=>
        connection_code_bits[$past(mem_access_address_reg)] == $past(cmd_lo) &&
        cm_data_field[$past(mem_access_address_reg)] == $past(mem_access_data_reg))
        else $error("code and data write wrong");
endmodule // sma_mem_access

// ---- inc/sma_pkg.sv ----
// Constants and types for the switch memory access command block
package sma_pkg;
    // Register bus
    localparam int SMA_ADDR_W = 8;
    localparam int SMA_DATA_W = 32;
    localparam logic [SMA_ADDR_W-1:0] SMA_OFF_DATA = 8'h00;
    localparam logic [SMA_ADDR_W-1:0] SMA_OFF_ADDR = 8'h04;
    localparam logic [SMA_ADDR_W-1:0] SMA_OFF_CMD = 8'h08;
    localparam logic [SMA_ADDR_W-1:0] SMA_OFF_STAT = 8'h0c;
    localparam int SMA_STAT_BUSY_BIT = 0;
    localparam logic [1:0] SMA_RESP_OKAY = 2'h0;
    localparam logic [1:0] SMA_RESP_SLVERR = 2'h2;

    // Register select codes
    localparam logic [2:0] SMA_SEL_DATA = 3'h0;
    localparam logic [2:0] SMA_SEL_ADDR = 3'h1;
    localparam logic [2:0] SMA_SEL_CMD = 3'h2;
    localparam logic [2:0] SMA_SEL_STAT = 3'h3;
    localparam logic [2:0] SMA_SEL_NONE = 3'h4;

    // Reset values
    localparam logic [7:0] SMA_RST_REG = 8'h00;
    localparam logic [7:0] SMA_RST_DM = 8'h00;
    localparam logic [3:0] SMA_RST_TS = 4'h0;
    localparam logic [3:0] SMA_RST_CODE = 4'h0;

    // Memory depths
    localparam int SMA_DM_DEPTH = 256;
    localparam int SMA_TS_DEPTH = 128;
    localparam int SMA_CM_DEPTH = 256;

    // Command bytes
    localparam logic [7:0] SMA_CMD_DM_RD = 8'h88;
    localparam logic [7:0] SMA_CMD_TS_WR = 8'h60;
    localparam logic [7:0] SMA_CMD_TS_ALL = 8'h68;
    localparam logic [7:0] SMA_CMD_TS_RD = 8'he0;
    localparam logic [7:0] SMA_CMD_CM_DWR = 8'h48;
    localparam logic [7:0] SMA_CMD_CM_DRD = 8'hc8;
    localparam logic [3:0] SMA_CMD_CM_CWR = 4'h7;
    localparam logic [3:0] SMA_CMD_CM_CRD = 4'hf;
    localparam logic [1:0] SMA_CMD_DM_WR_HI = 2'h0;
    localparam logic [2:0] SMA_CMD_DM_WR_LO = 3'h0;

    // Idle write bit position selects, command bits 5..3
    localparam logic [2:0] SMA_POS_8 = 3'h1;
    localparam logic [2:0] SMA_POS_HI4 = 3'h3;
    localparam logic [2:0] SMA_POS_LO4 = 3'h2;
    localparam logic [2:0] SMA_POS_B76 = 3'h7;
    localparam logic [2:0] SMA_POS_B54 = 3'h6;
    localparam logic [2:0] SMA_POS_B32 = 3'h5;
    localparam logic [2:0] SMA_POS_B10 = 3'h4;
    localparam logic [7:0] SMA_MASK_8 = 8'hff;
    localparam logic [7:0] SMA_MASK_HI4 = 8'hf0;
    localparam logic [7:0] SMA_MASK_LO4 = 8'h0f;
    localparam logic [7:0] SMA_MASK_B76 = 8'hc0;
    localparam logic [7:0] SMA_MASK_B54 = 8'h30;
    localparam logic [7:0] SMA_MASK_B32 = 8'h0c;
    localparam logic [7:0] SMA_MASK_B10 = 8'h03;

    typedef enum logic [3:0] {
        SMA_OP_NONE = 4'h0,
        SMA_OP_DM_WR = 4'h1,
        SMA_OP_DM_RD = 4'h2,
        SMA_OP_TS_WR = 4'h3,
        SMA_OP_TS_ALL = 4'h4,
        SMA_OP_TS_RD = 4'h5,
        SMA_OP_CM_DWR = 4'h6,
        SMA_OP_CM_DRD = 4'h7,
        SMA_OP_CM_CWR = 4'h8,
        SMA_OP_CM_CRD = 4'h9
    } sma_op_t;

    typedef enum logic {
        SMA_ST_IDLE = 1'b0,
        SMA_ST_EXEC = 1'b1
    } sma_state_t;
endpackage

// ---- core/sma_cmd_decode.sv ----
// Command byte decoder for the memory access block
`timescale 1ns/1ps
module sma_cmd_decode
    import sma_pkg::*;
(
    // Command byte
    input wire logic [7:0] mem_access_command_reg,
    // Decoded operation
    output sma_op_t op,
    output logic [7:0] dm_mask
);
    logic [2:0] pos;

    assign pos = mem_access_command_reg[5:3];

    always_comb
    begin
        op = SMA_OP_NONE;
        dm_mask = 8'h00;
        if (mem_access_command_reg[7:6] == SMA_CMD_DM_WR_HI &&
            mem_access_command_reg[2:0] == SMA_CMD_DM_WR_LO)
        begin
            op = SMA_OP_DM_WR;
            case (pos)
                SMA_POS_8: dm_mask = SMA_MASK_8;
                SMA_POS_HI4: dm_mask = SMA_MASK_HI4;
                SMA_POS_LO4: dm_mask = SMA_MASK_LO4;
                SMA_POS_B76: dm_mask = SMA_MASK_B76;
                SMA_POS_B54: dm_mask = SMA_MASK_B54;
                SMA_POS_B32: dm_mask = SMA_MASK_B32;
                SMA_POS_B10: dm_mask = SMA_MASK_B10;
                default: op = SMA_OP_NONE;
            endcase
        end
        else if (mem_access_command_reg[7:4] == SMA_CMD_CM_CWR)
        begin
            op = SMA_OP_CM_CWR;
        end
        else if (mem_access_command_reg[7:4] == SMA_CMD_CM_CRD)
        begin
            op = SMA_OP_CM_CRD;
        end
        else
        begin
            case (mem_access_command_reg)
                SMA_CMD_DM_RD: op = SMA_OP_DM_RD;
                SMA_CMD_TS_WR: op = SMA_OP_TS_WR;
                SMA_CMD_TS_ALL: op = SMA_OP_TS_ALL;
                SMA_CMD_TS_RD: op = SMA_OP_TS_RD;
                SMA_CMD_CM_DWR: op = SMA_OP_CM_DWR;
                SMA_CMD_CM_DRD: op = SMA_OP_CM_DRD;
                default: op = SMA_OP_NONE;
            endcase
        end
    end
endmodule // sma_cmd_decode

// ---- testbench/tb_top.sv ----
// Self-checking bench for the memory access command block
`timescale 1ns/1ps
module tb_top;
    import sma_pkg::*;
    logic aclk;
    logic aresetn;
    logic [SMA_ADDR_W-1:0] s_axi_awaddr;
    logic s_axi_awvalid;
    logic s_axi_awready;
    logic [SMA_DATA_W-1:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_wvalid;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready;
    logic [SMA_ADDR_W-1:0] s_axi_araddr;
    logic s_axi_arvalid;
    logic s_axi_arready;
    logic [SMA_DATA_W-1:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready;
    logic mem_access_busy;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    logic [31:0] v;
    logic [1:0] r;
    logic bz;
    logic [7:0] q;
    logic [7:0] exp;
    logic [7:0] d;
    logic [3:0] c;
    logic [7:0] idle_cmd [7] = '{8'h08, 8'h18, 8'h10, 8'h38, 8'h30, 8'h28, 8'h20};
    logic [7:0] idle_mask [7] = '{8'hff, 8'hf0, 8'h0f, 8'hc0, 8'h30, 8'h0c, 8'h03};

    sma_mem_access DUT (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .mem_access_busy(mem_access_busy)
    );

    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task summarize;
        if (error_cnt == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Hang guard
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            summarize();
        end
    end

    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask

    task automatic chk2(input string n, input logic [1:0] e, input logic [1:0] g);
        checks++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask

    // Write: both channels offered together, each dropped when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] wd, input logic [3:0] s,
                          output logic [1:0] rs, output logic b);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= wd;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        b = mem_access_busy;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rs);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // Load data, address, then command; poll busy; read data back
    task automatic mem_cmd(input logic [7:0] md, input logic [7:0] ma, input logic [7:0] mc,
                           output logic [7:0] mq);
        logic [1:0] rs;
        logic b;
        logic [31:0] rd;
        axi_wr(SMA_OFF_DATA, {24'h0, md}, 4'hf, rs, b);
        axi_wr(SMA_OFF_ADDR, {24'h0, ma}, 4'hf, rs, b);
        axi_wr(SMA_OFF_CMD, {24'h0, mc}, 4'hf, rs, b);
        chk2("cmd bresp", SMA_RESP_OKAY, rs);
        chk2("busy at cmd", 2'h1, {1'b0, b});
        do
            axi_rd(SMA_OFF_STAT, rd, rs);
        while (rd[SMA_STAT_BUSY_BIT] !== 1'b0);
        axi_rd(SMA_OFF_DATA, rd, rs);
        chk2("data rresp", SMA_RESP_OKAY, rs);
        mq = rd[7:0];
    endtask

    initial
    begin
        aresetn = 1'b0;
        s_axi_awaddr = '0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = '0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            axi_rd(8'(i * 4), v, r);
            chk8("reset reg", 8'h00, v[7:0]);
        end
        axi_rd(8'h10, v, r);
        chk2("unmapped rresp", SMA_RESP_SLVERR, r);
        axi_wr(8'h10, 32'h5, 4'hf, r, bz);
        chk2("unmapped bresp", SMA_RESP_SLVERR, r);
        axi_wr(SMA_OFF_CMD, 32'h88, 4'h0, r, bz);
        chk2("no strobe busy", 2'h0, {1'b0, bz});
        axi_wr(SMA_OFF_DATA, 32'h77, 4'h0, r, bz);
        axi_rd(SMA_OFF_DATA, v, r);
        chk8("no strobe data", 8'h00, v[7:0]);
        exp = 8'h00;
        for (int i = 0; i < 7; i++)
        begin
            d = 8'h5a + 8'(i * 59);
            mem_cmd(d, 8'h2a, idle_cmd[i], q);
            exp = (exp & ~idle_mask[i]) | (d & idle_mask[i]);
            mem_cmd(~exp, 8'h2a, SMA_CMD_DM_RD, q);
            chk8("idle dm", exp, q);
        end
        mem_cmd(8'h11, 8'h2a, 8'h01, q);
        mem_cmd(8'h99, 8'h2b, SMA_CMD_DM_RD, q);
        chk8("dm neighbour", 8'h00, q);
        mem_cmd(~exp, 8'h2a, SMA_CMD_DM_RD, q);
        chk8("dm after no-op", exp, q);
        mem_cmd(8'h09, 8'h8a, SMA_CMD_TS_WR, q);
        mem_cmd(8'hff, 8'h8a, SMA_CMD_TS_RD, q);
        chk8("ts single", 8'h09, q);
        mem_cmd(8'hff, 8'h15, SMA_CMD_TS_RD, q);
        chk8("ts other", 8'h00, q);
        mem_cmd(8'hf6, 8'h8a, SMA_CMD_TS_ALL, q);
        mem_cmd(8'hff, 8'h15, SMA_CMD_TS_RD, q);
        chk8("ts all a", 8'h06, q);
        mem_cmd(8'hff, 8'h7f, SMA_CMD_TS_RD, q);
        chk8("ts all b", 8'h06, q);
        for (int i = 0; i < 16; i++)
        begin
            c = 4'(i);
            mem_cmd(8'h30 + 8'(i), 8'hc0 + 8'(i), {4'h7, c}, q);
            mem_cmd(8'hff, 8'hc0 + 8'(i), {4'hf, ~c}, q);
            chk8("cm code", {4'h0, c}, q);
            mem_cmd(8'h00, 8'hc0 + 8'(i), SMA_CMD_CM_DRD, q);
            chk8("cm data", 8'h30 + 8'(i), q);
        end
        mem_cmd(8'hc6, 8'hc1, SMA_CMD_CM_DWR, q);
        mem_cmd(8'h00, 8'hc1, SMA_CMD_CM_DRD, q);
        chk8("cm data write", 8'hc6, q);
        mem_cmd(8'hff, 8'hc1, 8'hf0, q);
        chk8("cm code kept", 8'h01, q);
        mem_cmd(8'h00, 8'hc2, SMA_CMD_CM_DRD, q);
        chk8("cm neighbour", 8'h32, q);
        summarize();
    end
endmodule // tb_top
